// file: inc/stack_branch_cfg.svh
`ifndef STACK_BRANCH_CFG_SVH
`define STACK_BRANCH_CFG_SVH

`define SP_RESET       16'h0000
`define PC_RESET       16'h0000
`define STANDBY_CONTROL_REGISTER_RESET     8'h00
`define PSW_RESET      8'h00
`define STEP_ONE       16'h0001
`define STEP_TWO       16'h0002
`define STEP_THREE     16'h0003
`define STEP_FOUR      16'h0004
`define PSW_CY_BIT     0
`define PSW_AC_BIT     4
`define PSW_Z_BIT      6
`define PSW_RBS_LO     2
`define PSW_RBS_HI     3
`define PSW_IE_BIT     7
`define PSW_FLAG_MASK  8'h51

`endif

// file: inc/stack_branch_pkg.sv
package stack_branch_pkg;

  typedef enum logic [4:0] {
    op_nop,
    op_push_psw,
    op_push_sfr,
    op_push_pair,
    op_pop_psw,
    op_pop_sfr,
    op_pop_pair,
    op_sp_load_imm,
    op_sp_load_acc,
    op_sp_store_acc,
    op_sp_inc,
    op_sp_dec,
    op_jump_abs,
    op_jump_pair,
    op_jump_rel,
    op_jump_carry,
    op_jump_no_carry,
    op_jump_null,
    op_jump_nonnull,
    op_jump_bit_set,
    op_jump_bit_clear,
    op_jump_clear_bit,
    op_loop_reg,
    op_loop_mem,
    op_bank_choose,
    op_int_allow,
    op_int_block,
    op_standby_load
  } op_type;

  typedef struct packed {
    op_type      op;
    logic [2:0]  length;
    logic [15:0] word;
    logic [7:0]  offset;
    logic [7:0]  byte_val;
    logic [2:0]  bit_sel;
    logic [1:0]  bank;
    logic        bit_is_psw;
  } command_type;

  typedef struct packed {
    logic        write;
    logic        read;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mem_req_type;

  typedef enum logic [1:0] {
    phase_first,
    phase_second,
    phase_finish
  } phase_type;

endpackage

// file: hdl/jump_target.sv
`timescale 1ns/1ps
`include "stack_branch_cfg.svh"

module jump_target (
  // Operands
  input  wire logic [15:0] base_in,
  input  wire logic [2:0]  length_in,
  input  wire logic [7:0]  offset_in,
  input  wire logic        take_in,
  // Result
  output logic      [15:0] target_out
);

  logic [15:0] next_seq;

  always_comb begin
    next_seq   = base_in + {13'h0000, length_in};
    target_out = take_in ? next_seq + {{8{offset_in[7]}}, offset_in} : next_seq;
  end

endmodule // jump_target

// file: hdl/stack_branch_exec.sv
// Behaviour
// - Push status word or special register byte at stack minus one, stack drops one.
// - Push pair: high byte at stack minus one, low minus two, stack drops two.
// - Pop byte from stack, stack rises one; status pop replaces the whole status word.
// - Pop pair: low byte from stack, high from next, stack rises two.
// - Stack pointer loads immediate or accumulator pair, copies out, steps by one.
// - Unconditional jump: absolute, from pair, or relative plus two plus offset.
// - Carry jumps branch relative plus two on carry set or clear.
// - Null jumps branch relative plus two on zero flag set or clear.
// - Bit-set jump: three bytes for most forms, four for special register form.
// - Bit-clear jump: four bytes short-direct and special, three otherwise.
// - Jump-and-clear branches on set bit and clears it; status flags may change.
// - Loop jump decrements count, branches if nonzero; adds two or three.
// - Bank choose writes bank number zero to three into two-bit field.
// - Interrupt allow sets interrupt enable flag.
// - Interrupt block clears interrupt enable flag.
`timescale 1ns/1ps
`include "stack_branch_cfg.svh"

module stack_branch_exec (
  // Clock and reset
  input  wire logic                        clk_in,
  input  wire logic                        rstn_in,
  // Command
  input  wire logic                        cmd_valid_in,
  input  wire stack_branch_pkg::command_type cmd_in,
  output logic                             cmd_ready_out,
  output logic                             done_out,
  // Operands
  input  wire logic [15:0]                 pair_in,
  input  wire logic [15:0]                 acc_pair_in,
  input  wire logic [7:0]                  sfr_in,
  input  wire logic [7:0]                  test_byte_in,
  // Memory port
  output stack_branch_pkg::mem_req_type    mem_out,
  input  wire logic [7:0]                  mem_rdata_in,
  // Results
  output logic [15:0]                      pc_out,
  output logic [15:0]                      sp_out,
  output logic [7:0]                       psw_out,
  output logic [7:0]                       standby_control_register_out,
  output logic [15:0]                      result_word_out,
  output logic [7:0]                       result_byte_out,
  output logic                             pair_write_out,
  output logic                             sfr_write_out,
  output logic                             acc_write_out,
  output logic                             byte_write_out
);

  stack_branch_pkg::command_type cmd;
  stack_branch_pkg::command_type next_cmd;
  stack_branch_pkg::phase_type   phase;
  stack_branch_pkg::phase_type   next_phase;
  stack_branch_pkg::mem_req_type next_mem;
  logic [15:0] sp;
  logic [15:0] next_sp;
  logic [15:0] pc;
  logic [15:0] next_pc;
  logic [7:0]  program_status_word;
  logic [7:0]  next_psw;
  logic [7:0]  standby_control_register;
  logic [7:0]  next_standby_control_register;
  logic [7:0]  low_byte;
  logic [7:0]  next_low_byte;
  logic [15:0] next_word;
  logic [7:0]  next_byte;
  logic        next_pair_wr;
  logic        next_sfr_wr;
  logic        next_acc_wr;
  logic        next_byte_wr;
  logic        next_done;
  logic        busy;
  logic        next_busy;
  logic        take;
  logic        tested;
  logic [7:0]  dec_byte;
  logic [15:0] seq_target;

  function automatic logic [7:0] clear_bit(input logic [7:0] value, input logic [2:0] pos);
    logic [7:0] mask;
    mask = 8'h01 << pos;
    return value & ~mask;
  endfunction

  assign cmd_ready_out = ~busy;
  assign tested        = cmd.bit_is_psw ? program_status_word[cmd.bit_sel] : test_byte_in[cmd.bit_sel];
  assign dec_byte      = test_byte_in - 8'h01;

  always_comb begin
    unique case (cmd.op)
      stack_branch_pkg::op_jump_rel:       take = 1'b1;
      stack_branch_pkg::op_jump_carry:     take = program_status_word[`PSW_CY_BIT];
      stack_branch_pkg::op_jump_no_carry:  take = ~program_status_word[`PSW_CY_BIT];
      stack_branch_pkg::op_jump_null:      take = program_status_word[`PSW_Z_BIT];
      stack_branch_pkg::op_jump_nonnull:   take = ~program_status_word[`PSW_Z_BIT];
      stack_branch_pkg::op_jump_bit_set:   take = tested;
      stack_branch_pkg::op_jump_clear_bit: take = tested;
      stack_branch_pkg::op_jump_bit_clear: take = ~tested;
      stack_branch_pkg::op_loop_reg,
      stack_branch_pkg::op_loop_mem:       take = (dec_byte != 8'h00);
      default:                             take = 1'b0;
    endcase
  end

  // Length from command: 2/3/4 per form
  jump_target u_target (
    .base_in    (pc),
    .length_in  (cmd.length),
    .offset_in  (cmd.offset),
    .take_in    (take),
    .target_out (seq_target)
  );

  always_comb begin
    next_phase    = phase;
    next_cmd      = cmd;
    next_busy     = busy;
    next_mem      = '0;
    next_sp       = sp;
    next_pc       = pc;
    next_psw      = program_status_word;
    next_standby_control_register     = standby_control_register;
    next_low_byte = low_byte;
    next_word     = result_word_out;
    next_byte     = result_byte_out;
    next_pair_wr  = 1'b0;
    next_sfr_wr   = 1'b0;
    next_acc_wr   = 1'b0;
    next_byte_wr  = 1'b0;
    next_done     = 1'b0;
    if (!busy) begin
      if (cmd_valid_in) begin
        next_busy  = 1'b1;
        next_cmd   = cmd_in;
        next_phase = stack_branch_pkg::phase_first;
      end
    end else begin
      unique case (cmd.op)
        stack_branch_pkg::op_push_psw,
        stack_branch_pkg::op_push_sfr: begin
          next_mem.write = 1'b1;
          next_mem.addr  = sp - `STEP_ONE;
          next_mem.wdata = (cmd.op == stack_branch_pkg::op_push_psw) ? program_status_word : sfr_in;
          next_sp        = sp - `STEP_ONE;
          next_phase     = stack_branch_pkg::phase_finish;
        end
        stack_branch_pkg::op_push_pair: begin
          next_mem.write = 1'b1;
          if (phase == stack_branch_pkg::phase_first) begin
            next_mem.addr  = sp - `STEP_ONE;
            next_mem.wdata = pair_in[15:8];
            next_phase     = stack_branch_pkg::phase_second;
          end else begin
            next_mem.addr  = sp - `STEP_TWO;
            next_mem.wdata = pair_in[7:0];
            next_sp        = sp - `STEP_TWO;
            next_phase     = stack_branch_pkg::phase_finish;
          end
        end
        stack_branch_pkg::op_pop_psw,
        stack_branch_pkg::op_pop_sfr: begin
          if (phase == stack_branch_pkg::phase_first) begin
            next_mem.read = 1'b1;
            next_mem.addr = sp;
            next_phase    = stack_branch_pkg::phase_second;
          end else begin
            next_sp = sp + `STEP_ONE;
            if (cmd.op == stack_branch_pkg::op_pop_psw)
              next_psw = mem_rdata_in;
            else begin
              next_byte   = mem_rdata_in;
              next_sfr_wr = 1'b1;
            end
            next_phase = stack_branch_pkg::phase_finish;
          end
        end
        stack_branch_pkg::op_pop_pair: begin
          next_mem.read = (phase != stack_branch_pkg::phase_finish);
          if (phase == stack_branch_pkg::phase_first) begin
            next_mem.addr = sp;
            next_phase    = stack_branch_pkg::phase_second;
          end else if (phase == stack_branch_pkg::phase_second) begin
            next_mem.addr = sp + `STEP_ONE;
            next_low_byte = mem_rdata_in;
            next_phase    = stack_branch_pkg::phase_finish;
          end else begin
            next_word    = {mem_rdata_in, low_byte};
            next_pair_wr = 1'b1;
            next_sp      = sp + `STEP_TWO;
          end
        end
        stack_branch_pkg::op_sp_load_imm:  next_sp = cmd.word;
        stack_branch_pkg::op_sp_load_acc:  next_sp = acc_pair_in;
        stack_branch_pkg::op_sp_store_acc: begin
          next_word   = sp;
          next_acc_wr = 1'b1;
        end
        stack_branch_pkg::op_sp_inc:       next_sp = sp + `STEP_ONE;
        stack_branch_pkg::op_sp_dec:       next_sp = sp - `STEP_ONE;
        stack_branch_pkg::op_jump_clear_bit: begin
          if (tested && cmd.bit_is_psw)
            next_psw = clear_bit(program_status_word, cmd.bit_sel);
          else if (tested) begin
            next_byte    = clear_bit(test_byte_in, cmd.bit_sel);
            next_byte_wr = 1'b1;
          end
        end
        stack_branch_pkg::op_loop_reg,
        stack_branch_pkg::op_loop_mem: begin
          next_byte    = dec_byte;
          next_byte_wr = 1'b1;
        end
        stack_branch_pkg::op_bank_choose:
          next_psw[`PSW_RBS_HI:`PSW_RBS_LO] = cmd.bank;
        stack_branch_pkg::op_int_allow:    next_psw[`PSW_IE_BIT] = 1'b1;
        stack_branch_pkg::op_int_block:    next_psw[`PSW_IE_BIT] = 1'b0;
        stack_branch_pkg::op_standby_load: next_standby_control_register = cmd.byte_val;
        default: ;
      endcase
      // Finish: advance or redirect program counter
      if (next_phase == stack_branch_pkg::phase_finish || phase == stack_branch_pkg::phase_first &&
          next_phase == stack_branch_pkg::phase_first) begin
        unique case (cmd.op)
          stack_branch_pkg::op_jump_abs:  next_pc = cmd.word;
          stack_branch_pkg::op_jump_pair: next_pc = pair_in;
          default:                        next_pc = seq_target;
        endcase
        next_busy = 1'b0;
        next_done = 1'b1;
        if (cmd.op == stack_branch_pkg::op_pop_pair && phase != stack_branch_pkg::phase_finish) begin
          next_busy = 1'b1;
          next_done = 1'b0;
          next_pc   = pc;
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      busy            <= 1'b0;
      phase           <= stack_branch_pkg::phase_first;
      cmd             <= '0;
      sp              <= `SP_RESET;
      pc              <= `PC_RESET;
      program_status_word             <= `PSW_RESET;
      standby_control_register            <= `STANDBY_CONTROL_REGISTER_RESET;
      low_byte        <= 8'h00;
      mem_out         <= '0;
      result_word_out <= 16'h0000;
      result_byte_out <= 8'h00;
      pair_write_out  <= 1'b0;
      sfr_write_out   <= 1'b0;
      acc_write_out   <= 1'b0;
      byte_write_out  <= 1'b0;
      done_out        <= 1'b0;
    end else begin
      busy            <= next_busy;
      phase           <= next_phase;
      cmd             <= next_cmd;
      sp              <= next_sp;
      pc              <= next_pc;
      program_status_word             <= next_psw;
      standby_control_register            <= next_standby_control_register;
      low_byte        <= next_low_byte;
      mem_out         <= next_mem;
      result_word_out <= next_word;
      result_byte_out <= next_byte;
      pair_write_out  <= next_pair_wr;
      sfr_write_out   <= next_sfr_wr;
      acc_write_out   <= next_acc_wr;
      byte_write_out  <= next_byte_wr;
      done_out        <= next_done;
    end
  end

  assign pc_out   = pc;
  assign sp_out   = sp;
  assign psw_out  = program_status_word;
  assign standby_control_register_out = standby_control_register;

endmodule // stack_branch_exec

// file: tb/stack_branch_exec_asserts.sv
`timescale 1ns/1ps

module stack_branch_exec_asserts (
  // Clock and reset
  input wire logic                          clk_in,
  input wire logic                          rstn_in,
  // Command
  input wire logic                          cmd_valid_in,
  input wire stack_branch_pkg::command_type cmd_in,
  input wire logic                          cmd_ready_out,
  input wire logic                          done_out,
  input wire logic [15:0]                   pair_in,
  // Memory and state
  input wire stack_branch_pkg::mem_req_type mem_out,
  input wire logic [15:0]                   pc_out,
  input wire logic [15:0]                   sp_out,
  input wire logic [7:0]                    psw_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  stack_branch_pkg::command_type c;
  logic [15:0]                   s;
  logic [15:0]                   p;
  logic [7:0]                    f;
  logic [15:0]                   ds;
  wire  [15:0]                   seq = p + {13'h0, c.length};
  wire  [15:0]                   rel = seq + {{8{c.offset[7]}}, c.offset};

  // State seen when a command is taken
  always_ff @(posedge clk_in) begin
    if (cmd_valid_in && cmd_ready_out) begin
      c <= cmd_in;
      s <= sp_out;
      p <= pc_out;
      f <= psw_out;
    end
  end

  // Expected stack step per command
  always_comb begin
    case (c.op)
      stack_branch_pkg::op_push_psw, stack_branch_pkg::op_push_sfr, stack_branch_pkg::op_sp_dec: ds = 16'hFFFF;
      stack_branch_pkg::op_push_pair: ds = 16'hFFFE;
      stack_branch_pkg::op_pop_psw, stack_branch_pkg::op_pop_sfr, stack_branch_pkg::op_sp_inc: ds = 16'h0001;
      stack_branch_pkg::op_pop_pair: ds = 16'h0002;
      default: ds = 16'h0000;
    endcase
  end

  push_byte_addr_a: assert property (mem_out.write && (c.op == stack_branch_pkg::op_push_psw ||
    c.op == stack_branch_pkg::op_push_sfr) |-> mem_out.addr == s - 16'h0001) else $error("push byte address");
  push_psw_data_a: assert property (mem_out.write && c.op == stack_branch_pkg::op_push_psw
    |-> mem_out.wdata == f) else $error("push status data");
  push_pair_a: assert property (mem_out.write && c.op == stack_branch_pkg::op_push_pair |->
    (mem_out.addr == s - 16'h0001 && mem_out.wdata == pair_in[15:8]) ||
    (mem_out.addr == s - 16'h0002 && mem_out.wdata == pair_in[7:0])) else $error("push pair byte");
  pop_addr_a: assert property (mem_out.read |-> mem_out.addr == s ||
    (c.op == stack_branch_pkg::op_pop_pair && mem_out.addr == s + 16'h0001)) else $error("pop address");
  sp_step_a: assert property (done_out && c.op != stack_branch_pkg::op_sp_load_imm &&
    c.op != stack_branch_pkg::op_sp_load_acc |-> sp_out == s + ds) else $error("stack step");
  carry_jump_a: assert property (done_out && c.op == stack_branch_pkg::op_jump_carry
    |-> pc_out == (f[0] ? rel : seq)) else $error("carry jump target");
  nonnull_jump_a: assert property (done_out && c.op == stack_branch_pkg::op_jump_nonnull
    |-> pc_out == (f[6] ? seq : rel)) else $error("nonnull jump target");
  abs_jump_a: assert property (done_out && c.op == stack_branch_pkg::op_jump_abs
    |-> pc_out == c.word) else $error("absolute jump target");
  nop_step_a: assert property (done_out && c.op == stack_branch_pkg::op_nop
    |-> pc_out == seq && psw_out == f) else $error("nop changed state");
  ie_set_a: assert property (done_out && c.op == stack_branch_pkg::op_int_allow
    |-> psw_out[7] && psw_out[6:0] == f[6:0]) else $error("interrupt enable not set");
  ie_clear_a: assert property (done_out && c.op == stack_branch_pkg::op_int_block
    |-> !psw_out[7]) else $error("interrupt enable not cleared");
  bank_field_a: assert property (done_out && c.op == stack_branch_pkg::op_bank_choose
    |-> psw_out[3:2] == c.bank && psw_out[7:4] == f[7:4] && psw_out[1:0] == f[1:0]) else $error("bank field");

  cover property (mem_out.write && c.op == stack_branch_pkg::op_push_pair);
  cover property (done_out && c.op == stack_branch_pkg::op_jump_carry && f[0]);
  cover property (done_out && c.op == stack_branch_pkg::op_loop_mem);
endmodule // stack_branch_exec_asserts

bind stack_branch_exec stack_branch_exec_asserts stack_branch_exec_asserts_i (.clk_in(clk_in), .rstn_in(rstn_in),
  .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .cmd_ready_out(cmd_ready_out), .done_out(done_out),
  .pair_in(pair_in), .mem_out(mem_out), .pc_out(pc_out), .sp_out(sp_out), .psw_out(psw_out));

// file: tb/stack_branch_exec_tb_top.sv
`timescale 1ns/1ps

module stack_branch_exec_tb_top;
  logic                          clk_in = 1'b0;
  logic                          rstn_in = 1'b0;
  logic                          cmd_valid_in = 1'b0;
  stack_branch_pkg::command_type cmd_in = '0;
  logic [15:0]                   pair_in = 16'h1234;
  logic [15:0]                   acc_pair_in = 16'h0200;
  logic [7:0]                    sfr_in = 8'hA5;
  logic [7:0]                    test_byte_in = 8'h08;
  logic [7:0]                    mem_rdata_in;
  logic [3:0]                    strb;
  stack_branch_pkg::mem_req_type mem_out;
  logic                          cmd_ready_out, done_out, pair_write_out, sfr_write_out, acc_write_out, byte_write_out;
  logic [15:0]                   pc_out, sp_out, result_word_out;
  logic [7:0]                    psw_out, standby_control_register_out, result_byte_out;
  logic [7:0]                    mem [256];
  logic [15:0]                   epc = 16'h0000;
  int                            error_cnt = 0;
  int                            samples_checked = 0;

  always #20 clk_in = ~clk_in;

  stack_branch_exec stack_branch_exec_i (.clk_in(clk_in), .rstn_in(rstn_in), .cmd_valid_in(cmd_valid_in),
    .cmd_in(cmd_in), .cmd_ready_out(cmd_ready_out), .done_out(done_out), .pair_in(pair_in),
    .acc_pair_in(acc_pair_in), .sfr_in(sfr_in), .test_byte_in(test_byte_in), .mem_out(mem_out),
    .mem_rdata_in(mem_rdata_in), .pc_out(pc_out), .sp_out(sp_out), .psw_out(psw_out), .standby_control_register_out(standby_control_register_out),
    .result_word_out(result_word_out), .result_byte_out(result_byte_out), .pair_write_out(pair_write_out),
    .sfr_write_out(sfr_write_out), .acc_write_out(acc_write_out), .byte_write_out(byte_write_out));

  // Stack memory; read answers while the strobe stands, inverse data when idle
  always @(posedge clk_in) begin
    if (mem_out.write) mem[mem_out.addr[7:0]] <= mem_out.wdata;
  end
  assign mem_rdata_in = mem_out.read ? mem[mem_out.addr[7:0]] : ~mem[mem_out.addr[7:0]];

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    if (error_cnt == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // One command; word also carries byte, bit and bank operands
  task automatic run(input stack_branch_pkg::op_type op, input logic [2:0] len, input logic [15:0] w,
                     input logic [7:0] off, input logic [15:0] dpc);
    int n;
    n = 0;
    @(posedge clk_in);
    cmd_in <= '{op: op, length: len, word: w, offset: off, byte_val: w[7:0], bit_sel: w[2:0], bank: w[1:0],
                bit_is_psw: w[8]};
    cmd_valid_in <= 1'b1;
    @(posedge clk_in);
    cmd_valid_in <= 1'b0;
    #1;
    while (done_out !== 1'b1 && n < 20) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    strb = {pair_write_out, sfr_write_out, acc_write_out, byte_write_out};
    if (n == 20) error_cnt++;
    @(posedge clk_in);
    #1;
    epc = epc + {13'h0, len} + dpc;
    chk(pc_out, epc);
  endtask

  initial begin
    repeat (3000) @(posedge clk_in);
    error_cnt++;
    wrap_up();
  end

  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'h00;
    repeat (16) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    #1;
    run(stack_branch_pkg::op_sp_load_imm, 4, 16'h0080, 8'h00, 16'h0); chk(sp_out, 16'h0080);
    run(stack_branch_pkg::op_bank_choose, 2, 16'h0003, 8'h00, 16'h0); chk(psw_out, 8'h0C);
    run(stack_branch_pkg::op_int_allow, 1, 16'h0, 8'h00, 16'h0); chk(psw_out, 8'h8C);
    run(stack_branch_pkg::op_push_psw, 1, 16'h0, 8'h00, 16'h0); chk(sp_out, 16'h007F);
    chk(mem[8'h7F], 8'h8C);
    run(stack_branch_pkg::op_push_sfr, 2, 16'h0, 8'h00, 16'h0); chk(mem[8'h7E], 8'hA5);
    run(stack_branch_pkg::op_push_pair, 1, 16'h0, 8'h00, 16'h0); chk(sp_out, 16'h007C);
    chk({mem[8'h7D], mem[8'h7C]}, 16'h1234);
    run(stack_branch_pkg::op_pop_pair, 1, 16'h0, 8'h00, 16'h0); chk(result_word_out, 16'h1234);
    chk(sp_out, 16'h007E);
    chk(strb, 4'h8);
    run(stack_branch_pkg::op_pop_sfr, 2, 16'h0, 8'h00, 16'h0); chk(result_byte_out, 8'hA5);
    chk(strb, 4'h4);
    mem[8'h7F] = 8'h41;
    run(stack_branch_pkg::op_pop_psw, 1, 16'h0, 8'h00, 16'h0); chk(psw_out, 8'h41);
    chk(sp_out, 16'h0080);
    run(stack_branch_pkg::op_jump_carry, 2, 16'h0, 8'hF0, 16'hFFF0);
    run(stack_branch_pkg::op_jump_no_carry, 2, 16'h0, 8'hF0, 16'h0);
    run(stack_branch_pkg::op_jump_null, 2, 16'h0, 8'h10, 16'h0010);
    run(stack_branch_pkg::op_jump_nonnull, 2, 16'h0, 8'h10, 16'h0);
    run(stack_branch_pkg::op_jump_bit_set, 3, 16'h3, 8'h05, 16'h0005);
    run(stack_branch_pkg::op_jump_bit_set, 4, 16'h2, 8'h05, 16'h0);
    run(stack_branch_pkg::op_jump_bit_clear, 4, 16'h2, 8'h05, 16'h0005);
    run(stack_branch_pkg::op_jump_bit_clear, 3, 16'h3, 8'h05, 16'h0);
    run(stack_branch_pkg::op_jump_clear_bit, 3, 16'h3, 8'h05, 16'h0005); chk(result_byte_out, 8'h00);
    @(posedge clk_in) test_byte_in <= 8'h01;
    run(stack_branch_pkg::op_loop_reg, 2, 16'h0, 8'h05, 16'h0); chk(result_byte_out, 8'h00);
    @(posedge clk_in) test_byte_in <= 8'h05;
    run(stack_branch_pkg::op_loop_mem, 3, 16'h0, 8'hFB, 16'hFFFB); chk(result_byte_out, 8'h04);
    chk(strb, 4'h1);
    run(stack_branch_pkg::op_jump_abs, 3, 16'h1000, 8'h00, 16'h1000 - epc - 16'h3);
    @(posedge clk_in) pair_in <= 16'h2000;
    run(stack_branch_pkg::op_jump_pair, 2, 16'h0, 8'h00, 16'h2000 - epc - 16'h2);
    run(stack_branch_pkg::op_jump_rel, 2, 16'h0, 8'h7F, 16'h007F);
    run(stack_branch_pkg::op_int_allow, 1, 16'h0, 8'h00, 16'h0); chk(psw_out, 8'hC1);
    run(stack_branch_pkg::op_int_block, 1, 16'h0, 8'h00, 16'h0); chk(psw_out, 8'h41);
    run(stack_branch_pkg::op_standby_load, 4, 16'h005A, 8'h00, 16'h0); chk(standby_control_register_out, 8'h5A);
    run(stack_branch_pkg::op_nop, 1, 16'h0, 8'h00, 16'h0); chk(sp_out, 16'h0080);
    chk(psw_out, 8'h41);
    run(stack_branch_pkg::op_jump_clear_bit, 3, 16'h0106, 8'h05, 16'h0005); chk(psw_out, 8'h01);
    run(stack_branch_pkg::op_sp_load_acc, 2, 16'h0, 8'h00, 16'h0); chk(sp_out, 16'h0200);
    run(stack_branch_pkg::op_sp_inc, 2, 16'h0, 8'h00, 16'h0); chk(sp_out, 16'h0201);
    run(stack_branch_pkg::op_sp_dec, 2, 16'h0, 8'h00, 16'h0);
    run(stack_branch_pkg::op_sp_dec, 2, 16'h0, 8'h00, 16'h0); chk(sp_out, 16'h01FF);
    run(stack_branch_pkg::op_sp_store_acc, 2, 16'h0, 8'h00, 16'h0); chk(result_word_out, 16'h01FF);
    chk(strb, 4'h2);
    wrap_up();
  end
endmodule // stack_branch_exec_tb_top
